// *** include/velocity_monitor_params.svh ***
// register offsets, field positions, reset values and timing of the velocity window monitor
`ifndef VELOCITY_MONITOR_PARAMS_SVH
`define VELOCITY_MONITOR_PARAMS_SVH

// ************************************************************
// timing
// ************************************************************
`define CLK_PERIOD_NS 25
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define TP_PERIOD_MS 4'hf
`define TP_WIDTH_NS 500
`define TP_WIDTH_CYCLES ((`TP_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ************************************************************
// register map
// ************************************************************
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_OUTSEL 12'h008
`define REG_INST_BASE 12'h040
`define INST_COUNT 8
`define W_LIMITS 2'h0
`define W_TIMES 2'h1
`define W_DECEL 2'h2
`define W_STATE 2'h3

// ************************************************************
// fields
// ************************************************************
`define F_UPPER 0
`define F_LOWER 16
`define F_TIMEOUT 0
`define F_DWELL 8
`define F_DDELAY 16
`define F_REACT 24
`define F_SRC_IN 26
`define F_SRC_BUS 27
`define F_DECEL_EN 8
`define F_PAIR01 16
`define F_PAIR23 17

// ************************************************************
// reset values and state codes
// ************************************************************
`define CTRL_RST 32'h0000_0000
`define OUTSEL_RST 32'h0000_0000
`define LIM_LIMITS_RST 32'h0000_0001
`define RNG_LIMITS_RST 32'h0000_0000
`define TIMES_RST 32'h0101_0102
`define DECEL_RST 32'h0000_0000
`define CODE_IDLE 3'h0
`define CODE_WAIT 3'h1
`define CODE_MON 3'h2
`define CODE_FAIL 3'h5

`endif

// *** include/velocity_monitor_pkg.sv ***
// types shared by the velocity window monitor
package velocity_monitor_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WAIT = 4'h2,
      ST_MON = 4'h4,
      ST_FAIL = 4'h8
   } mon_state_t;
   typedef enum logic [1:0] {
      RC_NONE = 2'h0,
      RC_CUTOFF = 2'h1,
      RC_STOP_ONE = 2'h2,
      RC_STANDSTILL = 2'h3
   } reaction_t;
endpackage

// *** design/speed_window_monitor.sv ***
// report-only speed window check with in-range flag
`timescale 1ns/1ps
`include "velocity_monitor_params.svh"
module speed_window_monitor (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic signed [15:0] velocity,
   input wire logic signed [15:0] upperLimit,
   input wire logic signed [15:0] lowerLimit,
   output logic velocity_within_window,
   output logic [2:0] stateCode
);
   import velocity_monitor_pkg::*;
   logic velocity_within_window_ff, nxt_velocity_within_window;
   logic [2:0] code_ff, nxt_code;

   // no activation and no fault path: enable alone runs it
   always_comb begin
      nxt_velocity_within_window = enable && velocity >= lowerLimit && velocity <= upperLimit;
      nxt_code = enable ? `CODE_MON : `CODE_IDLE;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         velocity_within_window_ff <= 1'b0;
         code_ff <= `CODE_IDLE;
      end else begin
         velocity_within_window_ff <= nxt_velocity_within_window;
         code_ff <= nxt_code;
      end
   end

   assign velocity_within_window = velocity_within_window_ff;
   assign stateCode = code_ff;

   chk_window_flag: assert property (@(posedge clk) disable iff (sys_rst)
      enable && velocity >= lowerLimit && velocity <= upperLimit |=> velocity_within_window)
      else $error("in-range flag missing for velocity inside window");
endmodule

// *** design/activated_speed_monitor.sv ***
// activated speed monitor: limited-speed (absolute) or speed-range mode
`timescale 1ns/1ps
`include "velocity_monitor_params.svh"
module activated_speed_monitor (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic msTick,
   input wire logic enable,
   input wire logic activateReq,
   input wire logic absMode,
   input wire logic decelEn,
   input wire logic signed [15:0] velocity,
   input wire logic signed [15:0] upperLimit,
   input wire logic signed [15:0] lowerLimit,
   input wire logic [7:0] timeoutMs,
   input wire logic [7:0] dwellMs,
   input wire logic [7:0] decelDelayMs,
   input wire logic [15:0] decelLimit,
   output logic active,
   output logic [2:0] stateCode,
   output logic faultActive
);
   import velocity_monitor_pkg::*;
   mon_state_t state_ff, nxt_state;
   logic [7:0] elapsed_ff, nxt_elapsed, dwell_ff, nxt_dwell, elapsedInc;
   logic [16:0] ramp_ff, nxt_ramp, absVel;
   logic signed [16:0] sVel;
   logic inWin, overRamp, decelDue, run;

   always_comb begin
      sVel = {velocity[15], velocity};
      absVel = sVel[16] ? 17'(-sVel) : 17'(sVel);
      if (absMode)
         inWin = !upperLimit[15] && absVel <= {1'b0, upperLimit};
      else
         inWin = velocity >= lowerLimit && velocity <= upperLimit;
      overRamp = absVel > ramp_ff;
      decelDue = decelEn && elapsed_ff >= decelDelayMs;
      run = enable && activateReq;
      elapsedInc = (elapsed_ff == 8'hff) ? elapsed_ff : 8'(elapsed_ff + 8'h01);
      nxt_state = state_ff;
      nxt_elapsed = elapsed_ff;
      nxt_dwell = dwell_ff;
      nxt_ramp = ramp_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (run) begin
               nxt_state = ST_WAIT;
               nxt_elapsed = 8'h00;
               nxt_dwell = 8'h00;
               nxt_ramp = absVel;
            end
         end
         ST_WAIT: begin
            if (!run)
               nxt_state = ST_IDLE;
            else if (decelDue && overRamp)
               nxt_state = ST_FAIL;
            else if (msTick) begin
               nxt_elapsed = elapsedInc;
               nxt_dwell = inWin ? ((dwell_ff == 8'hff) ? dwell_ff : 8'(dwell_ff + 8'h01)) : 8'h00;
               nxt_ramp = (ramp_ff > {1'b0, decelLimit}) ? 17'(ramp_ff - {1'b0, decelLimit}) : 17'h0;
               // first of timeout or dwell inside limits wins
               if (elapsedInc >= timeoutMs || (inWin && nxt_dwell >= dwellMs))
                  nxt_state = ST_MON;
            end
         end
         ST_MON: begin
            if (!run)
               nxt_state = ST_IDLE;
            else if (!inWin)
               nxt_state = ST_FAIL;
         end
         ST_FAIL: begin
            // latched: dropping the request does not clear a fault
            if (!enable)
               nxt_state = ST_IDLE;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
         elapsed_ff <= 8'h00;
         dwell_ff <= 8'h00;
         ramp_ff <= 17'h0;
      end else begin
         state_ff <= nxt_state;
         elapsed_ff <= nxt_elapsed;
         dwell_ff <= nxt_dwell;
         ramp_ff <= nxt_ramp;
      end
   end

   always_comb begin
      active = state_ff == ST_MON || state_ff == ST_FAIL;
      faultActive = state_ff == ST_FAIL;
      unique case (state_ff)
         ST_WAIT: stateCode = `CODE_WAIT;
         ST_MON: stateCode = `CODE_MON;
         ST_FAIL: stateCode = `CODE_FAIL;
         default: stateCode = `CODE_IDLE;
      endcase
   end

   chk_fail_code: assert property (@(posedge clk) disable iff (sys_rst)
      faultActive |-> stateCode == 3'h5 && active)
      else $error("failed monitor not reporting code 5 and active");
   chk_window_exit: assert property (@(posedge clk) disable iff (sys_rst)
      state_ff == ST_MON && run && !inWin |=> faultActive && stateCode == 3'h5)
      else $error("leaving window while monitoring did not fault");
   chk_timeout_start: assert property (@(posedge clk) disable iff (sys_rst)
      state_ff == ST_WAIT && run && msTick && !(decelDue && overRamp) && elapsedInc >= timeoutMs
      |=> state_ff == ST_MON && active)
      else $error("activation timeout did not start monitoring");
   chk_decel_ramp: assert property (@(posedge clk) disable iff (sys_rst)
      state_ff == ST_WAIT && run && decelEn && elapsed_ff >= decelDelayMs && absVel > ramp_ff
      |=> faultActive)
      else $error("velocity above ramp did not fault");
   chk_no_early_fault: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(faultActive) |-> $past(state_ff == ST_MON) || $past(decelDue && overRamp))
      else $error("fault without monitoring or ramp violation");
endmodule

// *** design/safe_velocity_window_monitor.sv ***
// per-axis safe velocity supervision with apb registers and pulsed safe outputs
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "velocity_monitor_params.svh"
module safe_velocity_window_monitor #(
   parameter int MS_CYCLES = `MS_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signed [15:0] safeVelocity,
   input wire logic [5:0] fieldbusActivate,
   input wire logic [5:0] safeInputActivate,
   output logic [5:0] monitorActive,
   output logic [1:0] windowInRange,
   output logic torqueCutoffReq,
   output logic stopOneReq,
   output logic standstillStopReq,
   output logic [3:0] pulsedOut
);
   import velocity_monitor_pkg::*;

   // ************************************************************
   // address decode
   // ************************************************************
   // instance block index, or INST_COUNT when the address is not a word-aligned address inside one
   function automatic logic [3:0] instOf(input logic [11:0] a);
      logic [11:0] off;
      off = 12'(a - `REG_INST_BASE);
      if (a < `REG_INST_BASE || off[11:4] >= 8'(`INST_COUNT) || a[1:0] != 2'h0)
         instOf = 4'(`INST_COUNT);
      else
         instOf = off[7:4];
   endfunction

   // ************************************************************
   // registers
   // ************************************************************
   logic [31:0] ctrl_ff, nxt_ctrl, outsel_ff, nxt_outsel;
   logic [31:0] limits_ff [`INST_COUNT];
   logic [31:0] nxt_limits [`INST_COUNT];
   logic [31:0] times_ff [6];
   logic [31:0] nxt_times [6];
   logic [31:0] decel_ff [6];
   logic [31:0] nxt_decel [6];
   logic [31:0] prdata_ff, nxt_prdata;
   logic slverr_ff, nxt_slverr;
   logic wrEn, setup;
   logic [3:0] wrInst, rdInst;
   logic [1:0] wrWord, rdWord;

   // per-monitor state
   logic [5:0] monFault;
   logic [5:0] actReq;
   logic [2:0] monCode [6];
   logic [2:0] winCode [2];
   logic [31:0] statusWord;

   always_comb begin
      setup = psel && !penable;
      wrEn = psel && penable && pwrite;
      wrInst = instOf(paddr);
      wrWord = paddr[3:2];
      nxt_ctrl = ctrl_ff;
      nxt_outsel = outsel_ff;
      for (int i = 0; i < `INST_COUNT; i++)
         nxt_limits[i] = limits_ff[i];
      for (int i = 0; i < 6; i++) begin
         nxt_times[i] = times_ff[i];
         nxt_decel[i] = decel_ff[i];
      end
      if (wrEn) begin
         if (paddr == `REG_CTRL)
            nxt_ctrl = pwdata;
         else if (paddr == `REG_OUTSEL)
            nxt_outsel = pwdata;
         else if (wrInst != 4'(`INST_COUNT)) begin
            if (wrWord == `W_LIMITS)
               nxt_limits[wrInst[2:0]] = pwdata;
            else if (wrWord == `W_TIMES && wrInst < 4'h6)
               nxt_times[wrInst[2:0]] = pwdata;
            else if (wrWord == `W_DECEL && wrInst < 4'h6)
               nxt_decel[wrInst[2:0]] = pwdata;
         end
      end
   end

   // read data and error are prepared in the setup cycle so that the slave can
   // answer with zero wait states from flip-flops
   always_comb begin
      rdInst = instOf(paddr);
      rdWord = paddr[3:2];
      nxt_prdata = prdata_ff;
      nxt_slverr = slverr_ff;
      if (setup) begin
         nxt_prdata = 32'h0;
         nxt_slverr = 1'b0;
         if (paddr == `REG_CTRL)
            nxt_prdata = ctrl_ff;
         else if (paddr == `REG_STATUS && !pwrite)
            nxt_prdata = statusWord;
         else if (paddr == `REG_OUTSEL)
            nxt_prdata = outsel_ff;
         else if (rdInst == 4'(`INST_COUNT))
            nxt_slverr = 1'b1;
         else if (rdInst >= 4'h6) begin
            unique case (rdWord)
               `W_LIMITS: nxt_prdata = limits_ff[rdInst[2:0]];
               `W_STATE: nxt_prdata = {29'h0, winCode[rdInst[0]]};
               default: nxt_slverr = 1'b1;
            endcase
         end else begin
            unique case (rdWord)
               `W_LIMITS: nxt_prdata = limits_ff[rdInst[2:0]];
               `W_TIMES: nxt_prdata = times_ff[rdInst[2:0]];
               `W_DECEL: nxt_prdata = decel_ff[rdInst[2:0]];
               `W_STATE: nxt_prdata = {26'h0, monFault[rdInst[2:0]],
                                       monitorActive[rdInst[2:0]], 1'b0, monCode[rdInst[2:0]]};
            endcase
         end
         if (pwrite && (paddr == `REG_STATUS || (rdInst != 4'(`INST_COUNT) && rdWord == `W_STATE)))
            nxt_slverr = 1'b1;
         if (pwrite)
            nxt_prdata = 32'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_ff <= `CTRL_RST;
         outsel_ff <= `OUTSEL_RST;
         prdata_ff <= 32'h0;
         slverr_ff <= 1'b0;
         for (int i = 0; i < `INST_COUNT; i++)
            limits_ff[i] <= (i < 3) ? `LIM_LIMITS_RST : `RNG_LIMITS_RST;
         for (int i = 0; i < 6; i++) begin
            times_ff[i] <= `TIMES_RST;
            decel_ff[i] <= `DECEL_RST;
         end
      end else begin
         ctrl_ff <= nxt_ctrl;
         outsel_ff <= nxt_outsel;
         prdata_ff <= nxt_prdata;
         slverr_ff <= nxt_slverr;
         for (int i = 0; i < `INST_COUNT; i++)
            limits_ff[i] <= nxt_limits[i];
         for (int i = 0; i < 6; i++) begin
            times_ff[i] <= nxt_times[i];
            decel_ff[i] <= nxt_decel[i];
         end
      end
   end

   assign pready = 1'b1;
   assign prdata = prdata_ff;
   assign pslverr = slverr_ff && psel && penable;

   // ************************************************************
   // millisecond tick
   // ************************************************************
   logic [31:0] tickCnt_ff, nxt_tickCnt;
   logic msTick;

   always_comb begin
      msTick = tickCnt_ff == 32'(MS_CYCLES - 1);
      nxt_tickCnt = msTick ? 32'h0 : 32'(tickCnt_ff + 32'h1);
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         tickCnt_ff <= 32'h0;
      else
         tickCnt_ff <= nxt_tickCnt;
   end

   // ************************************************************
   // monitors
   // ************************************************************
   // 0..2 limited-speed, 3..5 speed-range
   for (genvar g = 0; g < 6; g++) begin : g_mon
      assign actReq[g] = (times_ff[g][`F_SRC_BUS] && fieldbusActivate[g])
                      || (times_ff[g][`F_SRC_IN] && safeInputActivate[g]);
      activated_speed_monitor u_mon (
         .clk(clk),
         .sys_rst(sys_rst),
         .msTick(msTick),
         .enable(ctrl_ff[g]),
         .activateReq(actReq[g]),
         .absMode(g < 3),
         .decelEn(ctrl_ff[`F_DECEL_EN + g]),
         .velocity(safeVelocity),
         .upperLimit(limits_ff[g][`F_UPPER +: 16]),
         .lowerLimit(limits_ff[g][`F_LOWER +: 16]),
         .timeoutMs(times_ff[g][`F_TIMEOUT +: 8]),
         .dwellMs(times_ff[g][`F_DWELL +: 8]),
         .decelDelayMs(times_ff[g][`F_DDELAY +: 8]),
         .decelLimit(decel_ff[g][15:0]),
         .active(monitorActive[g]),
         .stateCode(monCode[g]),
         .faultActive(monFault[g])
      );
   end

   for (genvar g = 0; g < 2; g++) begin : g_win
      speed_window_monitor u_win (
         .clk(clk),
         .sys_rst(sys_rst),
         .enable(ctrl_ff[6 + g]),
         .velocity(safeVelocity),
         .upperLimit(limits_ff[6 + g][`F_UPPER +: 16]),
         .lowerLimit(limits_ff[6 + g][`F_LOWER +: 16]),
         .velocity_within_window(windowInRange[g]),
         .stateCode(winCode[g])
      );
   end

   assign statusWord = {18'h0, monFault, windowInRange, monitorActive};

   // ************************************************************
   // fault reaction requests
   // ************************************************************
   logic cut_ff, stop_ff, hold_ff, nxt_cut, nxt_stop, nxt_hold;

   always_comb begin
      nxt_cut = 1'b0;
      nxt_stop = 1'b0;
      nxt_hold = 1'b0;
      for (int i = 0; i < 6; i++) begin
         if (monFault[i]) begin
            unique case (reaction_t'(times_ff[i][`F_REACT +: 2]))
               RC_CUTOFF: nxt_cut = 1'b1;
               RC_STOP_ONE: nxt_stop = 1'b1;
               RC_STANDSTILL: nxt_hold = 1'b1;
               RC_NONE: nxt_cut = 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cut_ff <= 1'b0;
         stop_ff <= 1'b0;
         hold_ff <= 1'b0;
      end else begin
         cut_ff <= nxt_cut;
         stop_ff <= nxt_stop;
         hold_ff <= nxt_hold;
      end
   end

   assign torqueCutoffReq = cut_ff;
   assign stopOneReq = stop_ff;
   assign standstillStopReq = hold_ff;

   // ************************************************************
   // pulsed safe outputs
   // ************************************************************
   // short low test pulse every period lets the load side detect a stuck output
   logic [3:0] tpMs_ff, nxt_tpMs;
   logic [7:0] tpCnt_ff, nxt_tpCnt;
   logic [3:0] out_ff, nxt_out;
   logic [3:0] sel [4];
   logic [7:0] srcVec;
   logic testLow;

   always_comb begin
      srcVec = {windowInRange, monitorActive};
      testLow = tpCnt_ff != 8'h0;
      nxt_tpMs = tpMs_ff;
      nxt_tpCnt = testLow ? 8'(tpCnt_ff - 8'h1) : 8'h0;
      if (msTick) begin
         nxt_tpMs = (tpMs_ff == `TP_PERIOD_MS) ? 4'h0 : 4'(tpMs_ff + 4'h1);
         if (tpMs_ff == `TP_PERIOD_MS)
            nxt_tpCnt = 8'(`TP_WIDTH_CYCLES);
      end
      for (int k = 0; k < 4; k++)
         sel[k] = outsel_ff[4 * k +: 4];
      if (outsel_ff[`F_PAIR01])
         sel[1] = sel[0];
      if (outsel_ff[`F_PAIR23])
         sel[3] = sel[2];
      for (int k = 0; k < 4; k++)
         nxt_out[k] = sel[k] != 4'h0 && sel[k] <= 4'h8 && srcVec[3'(sel[k] - 4'h1)] && !testLow;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tpMs_ff <= 4'h0;
         tpCnt_ff <= 8'h0;
         out_ff <= 4'h0;
      end else begin
         tpMs_ff <= nxt_tpMs;
         tpCnt_ff <= nxt_tpCnt;
         out_ff <= nxt_out;
      end
   end

   assign pulsedOut = out_ff;

   chk_react_route: assert property (@(posedge clk) disable iff (sys_rst)
      monFault[0] && times_ff[0][`F_REACT +: 2] == 2'h1 |=> torqueCutoffReq)
      else $error("torque cutoff not requested for failed monitor");
   chk_reset_defaults: assert property (@(posedge clk)
      $past(sys_rst) && !sys_rst |-> times_ff[0][7:0] == 8'h02 && times_ff[3][15:8] == 8'h01)
      else $error("activation timeout or dwell default wrong");
   chk_dual_channel: assert property (@(posedge clk) disable iff (sys_rst)
      outsel_ff[`F_PAIR01] && $stable(outsel_ff) |-> pulsedOut[0] == pulsedOut[1])
      else $error("paired outputs disagree");
endmodule

// *** tb/motion_feedback_model.sv ***
// far-side model: safe feedback velocity and the two activation sources
`timescale 1ns/1ps
module motion_feedback_model (
   input wire logic clk,
   input wire logic signed [15:0] velCmd,
   input wire logic [5:0] busCmd,
   input wire logic [5:0] pinCmd,
   output logic signed [15:0] safeVelocity,
   output logic [5:0] fieldbusActivate,
   output logic [5:0] safeInputActivate
);
   logic signed [15:0] nxt_vel;
   logic [5:0] nxt_bus;
   logic [5:0] nxt_pin;
   // both request paths are levels; a real source never glitches them mid-cycle
   always_comb begin
      nxt_vel = velCmd;
      nxt_bus = busCmd;
      nxt_pin = pinCmd;
   end
   always_ff @(posedge clk) begin
      safeVelocity <= nxt_vel;
      fieldbusActivate <= nxt_bus;
      safeInputActivate <= nxt_pin;
   end
endmodule

// *** tb/safe_velocity_window_monitor_tb.sv ***
// self-checking bench for the safe velocity window monitor
`timescale 1ns/1ps
module safe_velocity_window_monitor_tb;
   localparam int MSC = 10;
   typedef struct packed {logic signed [15:0] v; logic e;} row_t;
   row_t rows [4] = '{'{-16'sd11, 1'b0}, '{-16'sd10, 1'b1}, '{16'sd10, 1'b1}, '{16'sd11, 1'b0}};
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic cutReq, oneReq, holdReq;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic signed [15:0] velCmd = '0, safeVelocity;
   logic [5:0] busCmd = '0, pinCmd = '0, fbAct, inAct, monitorActive;
   logic [1:0] windowInRange;
   logic [3:0] pulsedOut;
   int n_fail = 0, n_compared = 0;
   int nLow, nDiff;
   motion_feedback_model motion_feedback_model_inst (.clk(clk), .velCmd(velCmd), .busCmd(busCmd),
      .pinCmd(pinCmd), .safeVelocity(safeVelocity), .fieldbusActivate(fbAct),
      .safeInputActivate(inAct));
   safe_velocity_window_monitor #(.MS_CYCLES(MSC)) safe_velocity_window_monitor_inst (
      .clk(clk), .sys_rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .safeVelocity(safeVelocity), .fieldbusActivate(fbAct), .safeInputActivate(inAct),
      .monitorActive(monitorActive), .windowInRange(windowInRange), .torqueCutoffReq(cutReq),
      .stopOneReq(oneReq), .standstillStopReq(holdReq), .pulsedOut(pulsedOut));
   initial begin
      forever #12.5 clk = ~clk;
   end
   // ****
   // shared tasks
   // ****
   task results;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // read data and error are taken at the edge that samples pready high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   initial begin
      #(25 * 8000);
      n_fail++;
      results;
   end
   // ****
   // tests
   // ****
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      apb(1, 12'h0a0, 32'hfff6_000a);
      apb(1, 12'h0b0, 32'hfff6_000a);
      apb(1, 12'h000, 32'hc0);
      foreach (rows[i]) begin
         velCmd <= rows[i].v;
         repeat (4) @(posedge clk);
         chk("in range", windowInRange, {2{rows[i].e}});
         chk("no reaction", {cutReq, oneReq, holdReq}, 0);
      end
      $display("window test done");
      apb(1, 12'h040, 32'h5);
      for (int r = 1; r < 4; r++) begin
         velCmd <= 0;
         // long timeout so only the dwell path can start monitoring
         apb(1, 12'h044, 32'h0801_0120 | (r << 24));
         apb(1, 12'h000, 32'h41);
         busCmd <= 6'h1;
         repeat (3 * MSC) @(posedge clk);
         chk("ls active", monitorActive[0], 1);
         velCmd <= -20;
         repeat (5) @(posedge clk);
         chk("reaction", {cutReq, oneReq, holdReq}, 3'b100 >> (r - 1));
         apb(0, 12'h04c, 0);
         chk("ls state", rd[5:0], 6'h35);
         busCmd <= 0;
         apb(1, 12'h000, 32'h40);
         repeat (3) @(posedge clk);
         chk("ls idle", monitorActive[0], 0);
      end
      $display("limited speed test done");
      apb(1, 12'h070, 32'h000a_0014);
      apb(1, 12'h074, 32'h0501_0102);
      apb(1, 12'h000, 32'h48);
      pinCmd <= 6'h8;
      repeat (5) @(posedge clk);
      chk("sr early", monitorActive[3], 0);
      repeat (4 * MSC) @(posedge clk);
      chk("sr fail", {monitorActive[3], cutReq}, 2'b11);
      apb(0, 12'h07c, 0);
      chk("sr state", rd[5:0], 6'h35);
      $display("speed range test done");
      // velocity held at 100 while the ramp drops 10 per ms; long dwell and
      // timeout keep monitor 4 waiting, so only the ramp check can fail it
      velCmd <= 100;
      apb(1, 12'h080, 32'h0000_00c8);
      apb(1, 12'h084, 32'h0a01_2020);
      apb(1, 12'h088, 32'h0000_000a);
      apb(1, 12'h000, 32'h1058);
      busCmd <= 6'h10;
      repeat (3 * MSC) @(posedge clk);
      chk("decel fail", {monitorActive[4], oneReq}, 2'b11);
      apb(0, 12'h08c, 0);
      chk("decel state", rd[5:0], 6'h35);
      $display("decel test done");
      // out0 follows monitor 3, out1 paired to it; one test pulse period is 160 cycles
      apb(1, 12'h008, 32'h0001_0004);
      repeat (2) @(posedge clk);
      nLow = 0;
      nDiff = 0;
      repeat (160) begin
         @(posedge clk);
         nLow += !pulsedOut[0];
         nDiff += pulsedOut[0] != pulsedOut[1];
      end
      chk("test pulse lows", nLow, 20);
      chk("pair diff", nDiff, 0);
      $display("pulsed output test done");
      // mid-run reset: registers written above must return to their defaults
      rst <= 1;
      repeat (3) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      chk("rst outputs", {monitorActive, windowInRange, cutReq, oneReq, holdReq, pulsedOut}, 0);
      apb(0, 12'h044, 0);
      chk("times0", rd, 32'h0101_0102);
      apb(0, 12'h074, 0);
      chk("times3", rd, 32'h0101_0102);
      apb(0, 12'h020, 0);
      chk("unmapped", err, 1);
      apb(1, 12'h004, 1);
      chk("ro status", err, 1);
      $display("reset test done");
      results;
   end
endmodule
